// >>> rtl/hps_power_ctrl.sv
// Power-state sequencer and process control for a haptic driver.
// Assumes analog detectors and the playback engine sit outside; pins are
// asynchronous and pass three-stage filters.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module hps_power_ctrl (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // AXI4-Lite slave
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Device pins
    input logic shutdown_n_pin,
    input logic trigger_irq_pin_i,
    output logic trigger_irq_pin_o,
    output logic trigger_irq_pin_oe,
    // Critical condition detectors
    input logic overcurrent_det,
    input logic undervoltage_det,
    input logic overtemp_det,
    // Playback engine
    input logic proc_done,
    input logic bemf_moving,
    input logic brake_done,
    input logic wave_amp_negative,
    output logic proc_run,
    output logic [1:0] proc_mode,
    output logic brake_cmd,
    output logic output_stage_en,
    output logic resonant_wave_shape,
    output logic [4:0] drive_time,
    output logic [3:0] current_decay_time,
    // Power control
    output logic core_power_en,
    output logic active_power_en,
    output logic [2:0] power_state
);

    // =================================================================
    // Pin filters
    logic [hps_pkg::NSYNC-1:0] pin_in;
    logic [hps_pkg::NSYNC-1:0] s1_q, s2_q, s3_q, filt_q;

    assign pin_in = {overtemp_det, undervoltage_det, overcurrent_det,
                     trigger_irq_pin_i, shutdown_n_pin};

    genvar gi;
    generate
        for (gi = 0; gi < hps_pkg::NSYNC; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    filt_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pin_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // Low shutdown pin holds registers, flags and state machine in reset; bus and pin filters keep running
    logic core_rst;
    assign core_rst = !aresetn || !filt_q[hps_pkg::SYN_SHDN];

    // =================================================================
    // Registers and bus
    hps_pkg::hps_state_t state_q;
    logic [31:0] ctrl_q, timing_q;
    logic [3:0] flags_q, irq_en_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic commit, rd_take, status_rd;
    logic [31:0] ctrl_new;
    logic cfg_change;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    assign commit = aw_full_q && w_full_q && !bvalid_q;
    assign rd_take = s_axi_arvalid && !rvalid_q;
    assign status_rd = rd_take && s_axi_araddr == hps_pkg::ADDR_STATUS;
    assign ctrl_new = merge(ctrl_q, wdata_q, wstrb_q)
                      & hps_pkg::CTRL_RW_MASK;
    // Writes while shut down still complete on the bus but are dropped, so defaults stay put
    assign cfg_change = commit && awaddr_q == hps_pkg::ADDR_CTRL
                        && ((ctrl_new ^ ctrl_q) & hps_pkg::CTRL_CFG_MASK)
                        != 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= hps_pkg::RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (commit) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q == hps_pkg::ADDR_CTRL
                            || awaddr_q == hps_pkg::ADDR_TIMING
                            || awaddr_q == hps_pkg::ADDR_STATUS
                            || awaddr_q == hps_pkg::ADDR_IRQ_EN)
                           ? hps_pkg::RESP_OKAY : hps_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= hps_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rresp_q <= hps_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                hps_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
                hps_pkg::ADDR_TIMING: rdata_q <= timing_q;
                hps_pkg::ADDR_STATUS: begin
                    rdata_q <= {25'h0, power_state, flags_q};
                end
                hps_pkg::ADDR_IRQ_EN: rdata_q <= {28'h0, irq_en_q};
                default: begin
                    rdata_q <= 32'h0;
                    rresp_q <= hps_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // =================================================================
    // Configuration decode
    logic [1:0] pin_func, mode;
    logic pulse_mode, level_mode, irq_mode, closed_loop, need_brake;
    logic trig_prev_q, trig_rise, trig_fall, critical, in_active;

    assign mode = ctrl_q[hps_pkg::MODE_LSB +: 2];
    assign pin_func = ctrl_q[hps_pkg::PINF_LSB +: 2];
    // Code 3 falls back to pulse trigger so the pin has one role
    assign irq_mode = pin_func == hps_pkg::PINF_IRQ;
    assign level_mode = pin_func == hps_pkg::PINF_LEVEL;
    assign pulse_mode = !irq_mode && !level_mode;
    assign closed_loop = ctrl_q[hps_pkg::LOOP_BIT];
    assign trig_rise = filt_q[hps_pkg::SYN_TRIG] && !trig_prev_q;
    assign trig_fall = !filt_q[hps_pkg::SYN_TRIG] && trig_prev_q;
    assign critical = filt_q[hps_pkg::SYN_OC] || filt_q[hps_pkg::SYN_UV]
                      || filt_q[hps_pkg::SYN_OT];
    assign in_active = state_q == hps_pkg::ST_CHECK
                       || state_q == hps_pkg::ST_RUN
                       || state_q == hps_pkg::ST_BRAKE;
    // Calibration never brakes after a stop; open loop needs its own enable
    assign need_brake = ctrl_q[hps_pkg::BBI_BIT]
                        && (closed_loop || ctrl_q[hps_pkg::OLB_BIT])
                        && bemf_moving && mode != hps_pkg::MODE_CAL;

    // No reset: a pin already high after shutdown must not look like a rise
    always_ff @(posedge aclk) begin
        trig_prev_q <= filt_q[hps_pkg::SYN_TRIG];
    end

    // Registers return to defaults whenever the core is held off
    always_ff @(posedge aclk) begin
        if (core_rst) begin
            timing_q <= hps_pkg::TIMING_RST;
            irq_en_q <= hps_pkg::IRQ_EN_RST;
        end else if (commit) begin
            if (awaddr_q == hps_pkg::ADDR_TIMING) begin
                timing_q <= merge(timing_q, wdata_q, wstrb_q)
                            & hps_pkg::TIMING_RW_MASK;
            end
            if (awaddr_q == hps_pkg::ADDR_IRQ_EN && wstrb_q[0]) begin
                irq_en_q <= wdata_q[3:0];
            end
        end
    end

    // Go bit: host writes and pin triggers both steer it
    always_ff @(posedge aclk) begin
        if (core_rst) begin
            ctrl_q <= hps_pkg::CTRL_RST;
        end else begin
            if (in_active && state_q != hps_pkg::ST_BRAKE
                && critical) begin
                ctrl_q[hps_pkg::GO_BIT] <= 1'b0;
            end else if (state_q == hps_pkg::ST_RUN && proc_done) begin
                ctrl_q[hps_pkg::GO_BIT] <= 1'b0;
            end
            if (commit && awaddr_q == hps_pkg::ADDR_CTRL) begin
                ctrl_q <= ctrl_new;
                if (cfg_change && state_q == hps_pkg::ST_RUN) begin
                    ctrl_q[hps_pkg::GO_BIT] <= 1'b0;
                end
            end
            if (!irq_mode) begin
                if (trig_rise) begin
                    // A pulse while running is a stop trigger
                    ctrl_q[hps_pkg::GO_BIT] <= !(pulse_mode && in_active);
                end else if (level_mode && trig_fall) begin
                    ctrl_q[hps_pkg::GO_BIT] <= 1'b0;
                end
            end
        end
    end

    // =================================================================
    // Power state machine
    logic stop_req;
    assign stop_req = !ctrl_q[hps_pkg::GO_BIT] || cfg_change;

    always_ff @(posedge aclk) begin
        if (core_rst) begin
            state_q <= hps_pkg::ST_OFF;
        end else begin
            unique case (state_q)
                hps_pkg::ST_OFF: state_q <= hps_pkg::ST_IDLE;
                hps_pkg::ST_IDLE: begin
                    if (ctrl_q[hps_pkg::GO_BIT]) begin
                        state_q <= hps_pkg::ST_CHECK;
                    end
                end
                hps_pkg::ST_CHECK: begin
                    state_q <= critical ? hps_pkg::ST_IDLE
                                        : hps_pkg::ST_RUN;
                end
                hps_pkg::ST_RUN: begin
                    if (critical) begin
                        state_q <= hps_pkg::ST_IDLE;
                    end else if (stop_req || proc_done) begin
                        state_q <= need_brake ? hps_pkg::ST_BRAKE
                                              : hps_pkg::ST_IDLE;
                    end
                end
                hps_pkg::ST_BRAKE: begin
                    if (critical || brake_done) begin
                        state_q <= hps_pkg::ST_IDLE;
                    end
                end
                default: state_q <= hps_pkg::ST_OFF;
            endcase
        end
    end

    // =================================================================
    // Sticky flags, cleared by a status read; a new event wins
    logic [3:0] flag_set;
    logic irq_q;
    assign flag_set[hps_pkg::FLAG_DONE] = state_q == hps_pkg::ST_RUN
        && proc_done && !critical && !stop_req
        && mode != hps_pkg::MODE_RTP;
    // Detectors are only watched in the active states
    assign flag_set[hps_pkg::FLAG_OC] = in_active
        && filt_q[hps_pkg::SYN_OC];
    assign flag_set[hps_pkg::FLAG_UV] = in_active && filt_q[hps_pkg::SYN_UV];
    assign flag_set[hps_pkg::FLAG_OT] = in_active && filt_q[hps_pkg::SYN_OT];

    always_ff @(posedge aclk) begin
        if (core_rst) begin
            flags_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            flags_q <= (status_rd ? 4'h0 : flags_q) | flag_set;
            irq_q <= irq_mode && (((status_rd ? 4'h0 : flags_q)
                     | flag_set) & irq_en_q) != 4'h0;
        end
    end

    // =================================================================
    // Outputs
    assign trigger_irq_pin_o = 1'b0;
    assign trigger_irq_pin_oe = irq_q;
    assign proc_run = state_q == hps_pkg::ST_RUN;
    assign proc_mode = mode;
    assign brake_cmd = state_q == hps_pkg::ST_BRAKE
        || (proc_run && ctrl_q[hps_pkg::OLB_BIT]
            && wave_amp_negative);
    assign output_stage_en = (proc_run || state_q == hps_pkg::ST_BRAKE)
                             && !filt_q[hps_pkg::SYN_OC];
    assign resonant_wave_shape = ctrl_q[hps_pkg::SHAPE_BIT]
        && !ctrl_q[hps_pkg::ACT_BIT] && !closed_loop;
    assign drive_time = timing_q[hps_pkg::DRIVE_LSB +: 5];
    assign current_decay_time = timing_q[hps_pkg::DECAY_LSB +: 4];
    assign core_power_en = state_q != hps_pkg::ST_OFF;
    assign active_power_en = in_active;
    assign power_state = {in_active, state_q == hps_pkg::ST_IDLE,
                          state_q == hps_pkg::ST_OFF};

    // =================================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_run_stop_brake;
        state_q == hps_pkg::ST_RUN && !critical && stop_req && need_brake;
    endsequence

    a_shdn_forces_off: assert property (
        !filt_q[hps_pkg::SYN_SHDN] |=> state_q == hps_pkg::ST_OFF)
        else $error("shutdown did not force off");
    a_off_to_idle: assert property (
        state_q == hps_pkg::ST_OFF && filt_q[hps_pkg::SYN_SHDN]
        |=> state_q == hps_pkg::ST_IDLE && ctrl_q == hps_pkg::CTRL_RST)
        else $error("no clean standby after shutdown release");
    a_crit_to_idle: assert property (
        in_active && critical && filt_q[hps_pkg::SYN_SHDN]
        |=> state_q == hps_pkg::ST_IDLE)
        else $error("critical condition did not reach standby");
    a_check_flags: assert property (
        state_q == hps_pkg::ST_CHECK && filt_q[hps_pkg::SYN_UV]
        && filt_q[hps_pkg::SYN_SHDN] |=> flags_q[hps_pkg::FLAG_UV])
        else $error("entry check did not flag undervoltage");
    a_brake_first: assert property (
        s_run_stop_brake and filt_q[hps_pkg::SYN_SHDN]
        |=> state_q == hps_pkg::ST_BRAKE ##1
            power_state[1] == 1'b0 || brake_done || critical)
        else $error("standby reported before braking");
    a_cfg_abort: assert property (
        state_q == hps_pkg::ST_RUN && cfg_change
        && filt_q[hps_pkg::SYN_SHDN] |=> state_q != hps_pkg::ST_RUN)
        else $error("mode change did not abort process");
    a_done_normal: assert property (
        $rose(flags_q[hps_pkg::FLAG_DONE]) |->
        $past(proc_run) && $past(proc_done)
        && $past(mode) != hps_pkg::MODE_RTP)
        else $error("done flag without normal completion");
    a_oc_stage_off: assert property (
        filt_q[hps_pkg::SYN_OC] |-> !output_stage_en)
        else $error("output stage on during short");
    a_idle_no_flag: assert property (
        state_q == hps_pkg::ST_IDLE && status_rd
        |=> !flags_q[hps_pkg::FLAG_OC])
        else $error("short flagged while idle");
    a_irq_pin: assert property (
        irq_mode && (flags_q & irq_en_q) != 4'h0 && !status_rd
        && filt_q[hps_pkg::SYN_SHDN] |=> trigger_irq_pin_oe)
        else $error("interrupt pin not pulled low");
    a_one_state: assert property ($onehot(power_state))
        else $error("power state not one-hot");

endmodule

// >>> common/hps_pkg.sv
// Constants, field layout and state codes of the haptic power-state control.
// Assumes a single 125 MHz clock and a register map reached over AXI4-Lite.
// =====================================================================
package hps_pkg;

    // =================================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMING = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;

    // =================================================================
    // Control fields
    localparam int GO_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int PINF_LSB = 3;
    localparam int ACT_BIT = 5;
    localparam int LOOP_BIT = 6;
    localparam int BBI_BIT = 7;
    localparam int OLB_BIT = 8;
    localparam int SHAPE_BIT = 9;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_CFG_MASK = 32'h0000_03fe;
    localparam logic [31:0] CTRL_RW_MASK = 32'h0000_03ff;

    // Timing fields
    localparam int DRIVE_LSB = 0;
    localparam int DECAY_LSB = 8;
    localparam logic [31:0] TIMING_RST = 32'h0000_0110;
    localparam logic [31:0] TIMING_RW_MASK = 32'h0000_0f1f;

    // Status fields
    localparam int FLAG_DONE = 0;
    localparam int FLAG_OC = 1;
    localparam int FLAG_UV = 2;
    localparam int FLAG_OT = 3;
    localparam int STATE_LSB = 4;
    localparam logic [3:0] IRQ_EN_RST = 4'hf;

    // =================================================================
    // Modes and pin functions
    localparam logic [1:0] MODE_RTP = 2'h0;
    localparam logic [1:0] MODE_SEQ = 2'h1;
    localparam logic [1:0] MODE_DIAG = 2'h2;
    localparam logic [1:0] MODE_CAL = 2'h3;
    localparam logic [1:0] PINF_PULSE = 2'h0;
    localparam logic [1:0] PINF_LEVEL = 2'h1;
    localparam logic [1:0] PINF_IRQ = 2'h2;

    // =================================================================
    // Pin synchroniser slots
    localparam int NSYNC = 5;
    localparam int SYN_SHDN = 0;
    localparam int SYN_TRIG = 1;
    localparam int SYN_OC = 2;
    localparam int SYN_UV = 3;
    localparam int SYN_OT = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_IDLE = 5'h02,
        ST_CHECK = 5'h04,
        ST_RUN = 5'h08,
        ST_BRAKE = 5'h10
    } hps_state_t;

endpackage

// >>> dv/hps_engine_model.sv
// Stand-in for the playback engine beside the power-state control.
// Assumes the control block's clock; the bench decides actuator motion.
`timescale 1ns/100ps
module hps_engine_model #(
    parameter int RUN_CYC = 10
) (
    // Clock
    input wire logic aclk,
    // Control side
    input wire logic proc_run,
    input wire logic brake_cmd,
    input wire logic hold_run,
    output logic proc_done,
    output logic brake_done
);
    int run_n = 0;
    // Hold keeps a run going so that stops and aborts can land mid-run
    always @(posedge aclk) begin
        run_n <= proc_run ? run_n + 1 : 0;
        proc_done <= proc_run && !hold_run && run_n == RUN_CYC;
        brake_done <= brake_cmd && !brake_done;
    end
    initial proc_done = 1'h0;
    initial brake_done = 1'h0;
endmodule

// >>> dv/haptic_power_state_control_bench.sv
// Self-checking bench for the haptic power-state control.
// Assumes the package and the engine stand-in are compiled first.
`timescale 1ns/100ps
module haptic_power_state_control_bench;
    // ============================================================
    // Signals
    logic aclk = 1'h0, aresetn = 1'h0, shutdown_n_pin = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, trig = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf, current_decay_time;
    logic overcurrent_det = 1'h0, undervoltage_det = 1'h0, hold = 1'h1;
    logic overtemp_det = 1'h0, bemf_moving = 1'h0, wave_amp_negative = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, proc_done, brake_done, proc_run, brake_cmd;
    logic output_stage_en, resonant_wave_shape, core_power_en;
    logic active_power_en, trigger_irq_pin_o, trigger_irq_pin_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp, proc_mode, rsp;
    logic [4:0] drive_time;
    logic [2:0] power_state;
    // Open-drain pin with pull-up: the host releases it high in irq mode
    wire trigger_irq_pin_i = trigger_irq_pin_oe ? trigger_irq_pin_o : trig;
    int bad_count = 0, compares = 0, runs = 0, brakes = 0, ctrl_m, t;
    int fb[7] = '{1, 3, 5, 6, 7, 8, 9};
    hps_power_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shutdown_n_pin,
        .trigger_irq_pin_i, .trigger_irq_pin_o, .trigger_irq_pin_oe,
        .overcurrent_det, .undervoltage_det, .overtemp_det, .proc_done,
        .bemf_moving, .brake_done, .wave_amp_negative, .proc_run,
        .proc_mode, .brake_cmd, .output_stage_en, .resonant_wave_shape,
        .drive_time, .current_decay_time, .core_power_en,
        .active_power_en, .power_state);
    hps_engine_model eng (.aclk, .proc_run, .brake_cmd, .hold_run(hold),
        .proc_done, .brake_done);
    initial forever #4 aclk = ~aclk;
    always @(negedge aclk) begin
        if (proc_run) runs++;
        if (brake_cmd) brakes++;
    end
    // ============================================================
    // Tasks
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Handshakes are sampled mid-cycle, so they reflect the edge to come
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        logic aw, w, ar, fin;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
        end
        fin = 1'h0;
        while (!fin) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            ar = s_axi_arvalid && s_axi_arready;
            fin = wr ? s_axi_bvalid : s_axi_rvalid;
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (ar) s_axi_arvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'h1, a, d);
        if (a == hps_pkg::ADDR_CTRL) ctrl_m = d & hps_pkg::CTRL_RW_MASK;
        check("bresp", 32'(hps_pkg::RESP_OKAY), 32'(rsp));
    endtask
    task automatic rdc(string what, logic [7:0] a, logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        check(what, exp, rd);
    endtask
    task automatic wait_ps(logic [2:0] s);
        int n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (power_state !== s && n < 80);
        check("power_state", 32'(s), 32'(power_state));
    endtask
    task automatic pulse();
        @(posedge aclk);
        trig <= 1'h1;
        repeat (6) @(posedge aclk);
        trig <= 1'h0;
        repeat (6) @(posedge aclk);
    endtask
    task automatic complete_run();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ============================================================
    // Scenarios
    initial begin
        void'($urandom(73803));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        wait_ps(3'h2);
        check("core_en", 32'h1, 32'(core_power_en));
        check("active", 32'h0, 32'(active_power_en));
        rdc("timing", hps_pkg::ADDR_TIMING, hps_pkg::TIMING_RST);
        t = $urandom & hps_pkg::TIMING_RW_MASK;
        wr(hps_pkg::ADDR_TIMING, t);
        check("drive", 32'(t[4:0]), 32'(drive_time));
        check("decay", 32'(t[11:8]), 32'(current_decay_time));
        rdc("timing", hps_pkg::ADDR_TIMING, t);
        hold <= 1'h0;
        for (int m = 0; m < 4; m++) begin
            wr(hps_pkg::ADDR_CTRL, 32'(m * 2 + 1));
            wait_ps(3'h4);
            check("mode", 32'(m), 32'(proc_mode));
            check("active", 32'h1, 32'(active_power_en));
            wait_ps(3'h2);
            rdc("status", hps_pkg::ADDR_STATUS, 32'(32 + (m != 0)));
        end
        hold <= 1'h1;
        bemf_moving <= 1'h1;
        wr(hps_pkg::ADDR_CTRL, 32'h0c2);
        pulse();
        wait_ps(3'h4);
        pulse();
        wait_ps(3'h2);
        check("braked", 32'h1, 32'(brakes > 0));
        brakes = 0;
        wr(hps_pkg::ADDR_CTRL, 32'h003);
        wait_ps(3'h4);
        wr(hps_pkg::ADDR_CTRL, 32'h002);
        wait_ps(3'h2);
        check("braked", 32'h0, 32'(brakes));
        wr(hps_pkg::ADDR_CTRL, 32'h0c3);
        wait_ps(3'h4);
        @(posedge aclk);
        overcurrent_det <= 1'h1;
        wait_ps(3'h2);
        check("stage", 32'h0, 32'(output_stage_en));
        check("braked", 32'h0, 32'(brakes));
        rdc("status", hps_pkg::ADDR_STATUS, 32'h22);
        repeat (8) @(posedge aclk);
        rdc("status", hps_pkg::ADDR_STATUS, 32'h20);
        runs = 0;
        wr(hps_pkg::ADDR_CTRL, 32'h003);
        wait_ps(3'h2);
        rdc("status", hps_pkg::ADDR_STATUS, 32'h22);
        check("runs", 32'h0, 32'(runs));
        overcurrent_det <= 1'h0;
        bemf_moving <= 1'h0;
        repeat (8) @(posedge aclk);
        foreach (fb[i]) begin
            wr(hps_pkg::ADDR_CTRL, 32'h003);
            wait_ps(3'h4);
            wr(hps_pkg::ADDR_CTRL, 32'h003 ^ (32'h1 << fb[i]));
            wait_ps(3'h2);
            wr(hps_pkg::ADDR_CTRL, 32'h002);
            wait_ps(3'h2);
        end
        wr(hps_pkg::ADDR_CTRL, 32'h10a);
        trig <= 1'h1;
        wait_ps(3'h4);
        @(posedge aclk);
        wave_amp_negative <= 1'h1;
        @(negedge aclk);
        check("neg_brake", 32'h1, 32'(brake_cmd));
        @(posedge aclk);
        wave_amp_negative <= 1'h0;
        trig <= 1'h0;
        wait_ps(3'h2);
        wr(hps_pkg::ADDR_CTRL, 32'h200);
        check("shape", 32'h1, 32'(resonant_wave_shape));
        wr(hps_pkg::ADDR_CTRL, 32'h240);
        check("shape", 32'h0, 32'(resonant_wave_shape));
        rdc("ctrl", hps_pkg::ADDR_CTRL, ctrl_m);
        wr(hps_pkg::ADDR_CTRL, 32'h010);
        trig <= 1'h1;
        overcurrent_det <= 1'h1;
        repeat (8) @(posedge aclk);
        wr(hps_pkg::ADDR_CTRL, 32'h011);
        wait_ps(3'h2);
        repeat (3) @(negedge aclk);
        check("irq_pin", 32'h0, 32'(trigger_irq_pin_i));
        @(posedge aclk);
        overcurrent_det <= 1'h0;
        rdc("status", hps_pkg::ADDR_STATUS, 32'h22);
        repeat (3) @(negedge aclk);
        check("irq_pin", 32'h1, 32'(trigger_irq_pin_i));
        wr(hps_pkg::ADDR_CTRL, 32'h003);
        wait_ps(3'h4);
        @(posedge aclk);
        shutdown_n_pin <= 1'h0;
        wait_ps(3'h1);
        check("core_en", 32'h0, 32'(core_power_en));
        check("run", 32'h0, 32'(proc_run));
        @(posedge aclk);
        shutdown_n_pin <= 1'h1;
        wait_ps(3'h2);
        rdc("ctrl", hps_pkg::ADDR_CTRL, hps_pkg::CTRL_RST);
        rdc("unmapped", 8'h40, 32'h0);
        check("rresp", 32'(hps_pkg::RESP_SLVERR), 32'(rsp));
        complete_run();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        bad_count++;
        complete_run();
    end
endmodule
